// File: src/ssdsu_unit.sv
`timescale 1ns/1ps
module ssdsu_unit (
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    input  wire ssdsu_pkg::ssdsu_issue_t issue,
    input  wire logic                    stores_done,
    input  wire logic                    loads_done,
    input  wire logic [3:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    output logic                         issue_ready,
    output ssdsu_pkg::ssdsu_result_t     result,
    output logic                         sticky_saturation_flag,
    output logic [3:0]                   greater_equal_flags,
    output logic                         spec_fence
);

    ssdsu_pkg::ssdsu_regs_t  st_q;
    ssdsu_pkg::ssdsu_regs_t  st_d;
    ssdsu_pkg::ssdsu_instr_t ins;
    logic                    take;
    logic                    top_ones;
    logic                    low_zero;
    logic                    is_mul;
    logic                    is_sax;
    logic                    is_sub;
    logic                    sat_shape;
    logic                    is_hsat;
    logic                    is_wsat;
    logic                    is_bar;
    logic                    bad_three;
    logic                    bad_two;
    logic                    undef;
    logic                    unpred;
    logic                    ok;
    logic [4:0]              amt;
    logic [31:0]             op2;
    logic signed [31:0]      prod_lo;
    logic signed [31:0]      prod_hi;
    logic [31:0]             mul_res;
    logic [31:0]             shifted;
    logic [32:0]             wsat;
    logic [31:0]             hsat_res;
    logic [1:0]              hsat_flag;
    logic [31:0]             hsub_res;
    logic [3:0]              hsub_ge;
    logic [16:0]             sax_sum;
    logic [16:0]             sax_diff;

    // Returns {clamped, value} for a signed value clamped to n bits
    function automatic logic [32:0] ssdsu_sat(
        input logic signed [32:0] v,
        input logic [5:0]         n
    );
        logic signed [32:0] hi;
        logic signed [32:0] lo;
        logic [32:0]        r;
        hi = (33'sh1 <<< (n - 6'h1)) - 33'sh1;
        lo = -hi - 33'sh1;
        if (v > hi) begin
            r = {1'b1, hi[31:0]};
        end else if (v < lo) begin
            r = {1'b1, lo[31:0]};
        end else begin
            r = {1'b0, v[31:0]};
        end
        return r;
    endfunction

    function automatic logic ssdsu_bad(input logic [3:0] r);
        return (r == ssdsu_pkg::REG_SP) || (r == ssdsu_pkg::REG_PC);
    endfunction

    assign ins      = issue.instr;
    assign take     = issue.valid & st_q.ready;
    assign top_ones = {ins.hi_bit, ins.shift_high_field} == ssdsu_pkg::HW2_ONES;
    assign low_zero = {ins.shift_low_field, ins.b5} == ssdsu_pkg::LOW3_ZERO;
    assign amt      = {ins.shift_high_field, ins.shift_low_field};

    assign is_mul    = (ins.op == ssdsu_pkg::MUL_SUB_OP) & top_ones & low_zero;
    assign is_sax    = (ins.op == ssdsu_pkg::SUB_ADD_OP) & top_ones & low_zero
                     & ~ins.exch_bit;
    assign is_sub    = (ins.op == ssdsu_pkg::HALF_SUB_OP) & top_ones & low_zero
                     & ~ins.exch_bit;
    assign sat_shape = ((ins.op & ssdsu_pkg::SAT_OP_MASK)
                        == ssdsu_pkg::SAT_OP_MATCH) & ~ins.hi_bit;
    // Arithmetic shift of zero is the dual-halfword form
    assign is_hsat   = sat_shape & ins.op[ssdsu_pkg::SH_POS]
                     & (amt == ssdsu_pkg::SHIFT_NONE); // RQ9
    assign is_wsat   = sat_shape & ~is_hsat;
    assign is_bar    = ins == ssdsu_pkg::BARRIER_WORD;

    assign bad_two   = ssdsu_bad(ins.rd) | ssdsu_bad(ins.rn);
    assign bad_three = bad_two | ssdsu_bad(ins.rm);
    assign undef  = ((is_mul | is_sax | is_sub | is_hsat) & ~st_q.dsp_en)
                  | ((is_wsat | is_bar) & ~st_q.main_en); // RQ5 RQ20
    assign unpred = ~undef
                  & (((is_mul | is_sax | is_sub) & bad_three) // RQ6
                  | ((is_hsat | is_wsat) & bad_two) // RQ7
                  | (is_bar & issue.in_it)); // RQ20
    assign ok = take & ~undef & ~unpred;

    // Dual multiply-subtract
    assign op2 = ins.exch_bit ? {issue.rm_val[15:0], issue.rm_val[31:16]}
                              : issue.rm_val; // RQ4
    assign prod_lo = $signed(issue.rn_val[15:0]) * $signed(op2[15:0]); // RQ1
    assign prod_hi = $signed(issue.rn_val[31:16]) * $signed(op2[31:16]);
    assign mul_res = prod_lo - prod_hi; // RQ2

    // Word saturate with optional shift
    // Cast keeps the right shift signed inside the unsigned select
    assign shifted = ins.op[ssdsu_pkg::SH_POS]
                   ? $unsigned($signed(issue.rn_val) >>> amt) // RQ9
                   : issue.rn_val << amt; // RQ10
    assign wsat = ssdsu_sat({shifted[31], shifted},
                            {1'b0, ins.exch_bit, ins.rm} + 6'h01); // RQ8

    // Per-halfword saturate and subtract
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_half
            logic [15:0] a;
            logic [15:0] b;
            logic [32:0] s;
            logic [16:0] dif;
            assign a = issue.rn_val[g*ssdsu_pkg::HALF_W +: ssdsu_pkg::HALF_W];
            assign b = issue.rm_val[g*ssdsu_pkg::HALF_W +: ssdsu_pkg::HALF_W];
            assign s = ssdsu_sat({{17{a[15]}}, a},
                                 {2'h0, ins.rm} + 6'h01); // RQ12 RQ13
            assign hsat_res[g*ssdsu_pkg::HALF_W +: ssdsu_pkg::HALF_W] =
                s[15:0];
            assign hsat_flag[g] = s[32];
            assign dif = {a[15], a} - {b[15], b}; // RQ16
            assign hsub_res[g*ssdsu_pkg::HALF_W +: ssdsu_pkg::HALF_W] =
                dif[15:0];
            assign hsub_ge[2*g +: 2] = {2{~dif[16]}}; // RQ17
        end
    endgenerate

    assign sax_sum  = {issue.rn_val[15], issue.rn_val[15:0]}
                    + {issue.rm_val[31], issue.rm_val[31:16]}; // RQ14
    assign sax_diff = {issue.rn_val[31], issue.rn_val[31:16]}
                    - {issue.rm_val[15], issue.rm_val[15:0]};

    always_comb begin
        st_d            = st_q;
        st_d.res.valid  = 1'b0;
        st_d.res.undef  = take & undef;
        st_d.res.unpred = take & unpred;
        st_d.rdata      = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                ssdsu_pkg::ADDR_CTRL: begin
                    st_d.rdata[ssdsu_pkg::CTRL_DSP_POS]  = st_q.dsp_en;
                    st_d.rdata[ssdsu_pkg::CTRL_MAIN_POS] = st_q.main_en;
                end
                ssdsu_pkg::ADDR_FLAGS: begin
                    st_d.rdata[3:0]                   = st_q.ge;
                    st_d.rdata[ssdsu_pkg::FLAG_Q_POS] = st_q.q;
                end
                default: begin
                    st_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (reg_wr && reg_addr == ssdsu_pkg::ADDR_CTRL) begin
            st_d.dsp_en  = reg_wdata[ssdsu_pkg::CTRL_DSP_POS];
            st_d.main_en = reg_wdata[ssdsu_pkg::CTRL_MAIN_POS];
        end
        if (reg_wr && reg_addr == ssdsu_pkg::ADDR_FLAGS) begin
            st_d.q  = reg_wdata[ssdsu_pkg::FLAG_Q_POS];
            st_d.ge = reg_wdata[3:0];
        end
        // Instruction updates come after so a set beats a software clear
        if (ok) begin
            st_d.res.rd = ins.rd;
            if (is_mul) begin
                st_d.res.valid = 1'b1;
                st_d.res.data  = mul_res; // RQ3
            end
            if (is_wsat) begin
                st_d.res.valid = 1'b1;
                st_d.res.data  = wsat[31:0]; // RQ8
                if (wsat[32]) begin
                    st_d.q = 1'b1; // RQ11
                end
            end
            if (is_hsat) begin
                st_d.res.valid = 1'b1;
                st_d.res.data  = hsat_res; // RQ12
                if (|hsat_flag) begin
                    st_d.q = 1'b1; // RQ11
                end
            end
            if (is_sax) begin
                st_d.res.valid = 1'b1;
                st_d.res.data  = {sax_diff[15:0], sax_sum[15:0]}; // RQ14
                st_d.ge = {{2{~sax_diff[16]}}, {2{~sax_sum[16]}}}; // RQ15
            end
            if (is_sub) begin
                st_d.res.valid = 1'b1;
                st_d.res.data  = hsub_res; // RQ16
                st_d.ge        = hsub_ge; // RQ17
            end
        end
        case (st_q.st)
            ssdsu_pkg::ST_RUN: begin
                if (ok && is_bar) begin
                    // Hold younger loads and stores until older ones settle
                    st_d.st    = ssdsu_pkg::ST_FENCE;
                    st_d.fence = 1'b1; // RQ18 RQ19
                    st_d.ready = 1'b0;
                end
            end
            ssdsu_pkg::ST_FENCE: begin
                if (stores_done && loads_done) begin
                    st_d.st    = ssdsu_pkg::ST_RUN;
                    st_d.fence = 1'b0; // RQ18 RQ19
                    st_d.ready = 1'b1;
                end
            end
            default: begin
                st_d.st = ssdsu_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q            <= '0;
            st_q.st         <= ssdsu_pkg::ST_RUN;
            st_q.ready      <= 1'b1;
            st_q.q          <= ssdsu_pkg::Q_RESET;
            st_q.ge         <= ssdsu_pkg::GE_RESET;
            st_q.dsp_en     <= ssdsu_pkg::DSP_EN_RESET;
            st_q.main_en    <= ssdsu_pkg::MAIN_EN_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata              = st_q.rdata;
    assign issue_ready            = st_q.ready;
    assign result                 = st_q.res;
    assign sticky_saturation_flag = st_q.q;
    assign greater_equal_flags    = st_q.ge;
    assign spec_fence             = st_q.fence;

    // Checks
    logic [31:0] chk_mul;
    logic        flag_wr;
    assign chk_mul = 32'($signed(issue.rn_val[15:0]) * $signed(op2[15:0])
                   - $signed(issue.rn_val[31:16]) * $signed(op2[31:16]));
    assign flag_wr = reg_wr && reg_addr == ssdsu_pkg::ADDR_FLAGS;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    property p_mul_value;
        ok && is_mul |=> result.valid && result.data == $past(chk_mul);
    endproperty
    a_mul_value: assert property (p_mul_value) // RQ1
        else $error("dual multiply-subtract result wrong");

    property p_mul_q;
        ok && is_mul && !flag_wr |=> $stable(sticky_saturation_flag);
    endproperty
    a_mul_q: assert property (p_mul_q) // RQ3
        else $error("multiply-subtract changed sticky flag");

    property p_undef_dsp;
        take && (is_mul || is_sub || is_sax) && !st_q.dsp_en
            |=> result.undef && !result.valid;
    endproperty
    a_undef_dsp: assert property (p_undef_dsp) // RQ5
        else $error("missing undefined without DSP extension");

    property p_unpred_three;
        take && st_q.dsp_en && is_sub && ins.rd == ssdsu_pkg::REG_PC
            |=> result.unpred && !result.valid;
    endproperty
    a_unpred_three: assert property (p_unpred_three) // RQ6
        else $error("register 15 not flagged unpredictable");

    property p_q_sticky;
        $fell(sticky_saturation_flag) |-> $past(flag_wr);
    endproperty
    a_q_sticky: assert property (p_q_sticky) // RQ11
        else $error("sticky flag cleared by hardware");

    property p_sat_one_bit;
        ok && is_wsat && {ins.exch_bit, ins.rm} == 5'h00
            |=> result.data == 32'h0000_0000
             || result.data == 32'hFFFF_FFFF;
    endproperty
    a_sat_one_bit: assert property (p_sat_one_bit) // RQ8
        else $error("one-bit word saturate out of range");

    property p_ge_pairs;
        ok && (is_sax || is_sub) |=> greater_equal_flags[1]
            == greater_equal_flags[0] && greater_equal_flags[3]
            == greater_equal_flags[2];
    endproperty
    a_ge_pairs: assert property (p_ge_pairs) // RQ15
        else $error("flag pair split");

    property p_fence_hold;
        spec_fence && !(stores_done && loads_done)
            |=> spec_fence && !issue_ready;
    endproperty
    a_fence_hold: assert property (p_fence_hold) // RQ18
        else $error("barrier released early");

    property p_fence_start;
        ok && is_bar |=> spec_fence ##1 (spec_fence || $past(stores_done));
    endproperty
    a_fence_start: assert property (p_fence_start) // RQ19
        else $error("barrier did not raise fence");

    property p_bar_it;
        take && is_bar && issue.in_it && st_q.main_en
            |=> result.unpred && !spec_fence;
    endproperty
    a_bar_it: assert property (p_bar_it) // RQ20
        else $error("barrier in block not unpredictable");

    property p_sar_sign;
        ok && is_wsat && ins.op[ssdsu_pkg::SH_POS] && issue.rn_val[31]
            && {ins.exch_bit, ins.rm} == 5'h1F |=> result.data[31];
    endproperty
    a_sar_sign: assert property (p_sar_sign) // RQ9
        else $error("right shift lost the sign");

    property p_hsat_q;
        ok && is_hsat && (|hsat_flag) |=> sticky_saturation_flag;
    endproperty
    a_hsat_q: assert property (p_hsat_q) // RQ11
        else $error("halfword clamp did not set sticky flag");

    property p_bar_no_write;
        ok && is_bar |=> !result.valid && !result.undef;
    endproperty
    a_bar_no_write: assert property (p_bar_no_write) // RQ18
        else $error("barrier wrote a register");

endmodule

// File: src/ssdsu_pkg.sv
// What this block does
// RQ1: Dual multiply-subtract of two halfword signed products
// RQ2: Result is low product minus high product
// RQ3: Dual multiply-subtract leaves saturation flag alone
// RQ4: Exchange bit swaps second operand halfwords
// RQ5: Group instructions undefined without DSP extension
// RQ6: Three-register forms: registers 13, 15 unpredictable
// RQ7: Dual-halfword saturate: registers 13, 15 unpredictable
// RQ8: Word saturate clamps to field-plus-one bit range
// RQ9: Shift-type one: arithmetic right by shift fields
// RQ10: Shift-type zero: logical left by shift fields
// RQ11: Any clamping sets sticky flag, never clears
// RQ12: Dual-halfword saturate clamps each half independently
// RQ13: Halfword saturate position is field plus one
// RQ14: Exchange form: difference high, sum low
// RQ15: Exchange form sets flag pairs from signs
// RQ16: Dual halfword subtract writes both differences
// RQ17: Subtract flag pairs follow each difference sign
// RQ18: Later loads never bypass older same-address stores
// RQ19: Earlier loads never see younger same-address stores
// RQ20: Barrier undefined without main, unpredictable in block
package ssdsu_pkg;

    localparam int HALF_W = 16;
    localparam int WORD_W = 32;

    localparam logic [11:0] MUL_SUB_OP    = 12'hFB4;
    localparam logic [11:0] SUB_ADD_OP    = 12'hFAE;
    localparam logic [11:0] HALF_SUB_OP   = 12'hFAD;
    localparam logic [11:0] SAT_OP_MASK   = 12'hFBD;
    localparam logic [11:0] SAT_OP_MATCH  = 12'hF30;
    localparam int          SH_POS        = 1;
    localparam logic [3:0]  HW2_ONES      = 4'hF;
    localparam logic [2:0]  LOW3_ZERO     = 3'h0;
    localparam logic [4:0]  SHIFT_NONE    = 5'h00;
    localparam logic [31:0] BARRIER_WORD  = 32'hF3BF_8F40;
    localparam logic [3:0]  REG_SP        = 4'hD;
    localparam logic [3:0]  REG_PC        = 4'hF;

    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_FLAGS    = 4'h4;
    localparam int          CTRL_DSP_POS  = 0;
    localparam int          CTRL_MAIN_POS = 1;
    localparam int          FLAG_Q_POS    = 4;
    localparam logic        DSP_EN_RESET  = 1'b1;
    localparam logic        MAIN_EN_RESET = 1'b1;
    localparam logic        Q_RESET       = 1'b0;
    localparam logic [3:0]  GE_RESET      = 4'h0;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_FENCE
    } ssdsu_state_t;

    typedef struct packed {
        logic [11:0] op;
        logic [3:0]  rn;
        logic        hi_bit;
        logic [2:0]  shift_high_field;
        logic [3:0]  rd;
        logic [1:0]  shift_low_field;
        logic        b5;
        logic        exch_bit;
        logic [3:0]  rm;
    } ssdsu_instr_t;

    typedef struct packed {
        logic         valid;
        ssdsu_instr_t instr;
        logic [31:0]  rn_val;
        logic [31:0]  rm_val;
        logic         in_it;
    } ssdsu_issue_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  rd;
        logic [31:0] data;
        logic        undef;
        logic        unpred;
    } ssdsu_result_t;

    typedef struct packed {
        ssdsu_state_t  st;
        logic          ready;
        ssdsu_result_t res;
        logic          q;
        logic [3:0]    ge;
        logic          fence;
        logic          dsp_en;
        logic          main_en;
        logic [31:0]   rdata;
    } ssdsu_regs_t;

endpackage

// File: verif/ssdsu_mem_model.sv
`timescale 1ns/1ps
module ssdsu_mem_model #(
    parameter int STORE_LAT = 2,
    parameter int LOAD_LAT  = 4
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic spec_fence,
    output logic      stores_done,
    output logic      loads_done
);
    logic [3:0] cnt_q;

    // Drain counter restarts whenever no barrier is holding
    always_ff @(posedge clk_sys) begin
        if (!rstn || !spec_fence) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Older stores drain first, older loads later
    assign stores_done = spec_fence && (cnt_q >= STORE_LAT);
    assign loads_done  = spec_fence && (cnt_q >= LOAD_LAT);
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct {
        logic [31:0] ins, a, b, data;
        logic [3:0]  ge;
        logic        q;
    } ssdsu_row_t;

    logic                     clk_sys, rstn, stores_done, loads_done;
    logic                     reg_wr, reg_rd, issue_ready, spec_fence;
    logic                     sticky_saturation_flag;
    logic [3:0]               reg_addr, greater_equal_flags;
    logic [31:0]              reg_wdata, reg_rdata, rv;
    ssdsu_pkg::ssdsu_issue_t  issue;
    ssdsu_pkg::ssdsu_result_t result;
    int                       n_mismatch, checked, k;
    logic [31:0]              ins;
    int                       pos_a [3] = '{16, 8, 0};
    logic [31:0]              dsp_a [5] = '{32'hFB42_F103, 32'hFB42_F113,
                                            32'hFAD2_F103, 32'hFAE2_F103,
                                            32'hF322_0103};
    ssdsu_row_t rows [12] = '{
    '{32'hFB42_F103, 32'h0003_0002, 32'h0005_0004, 32'hFFFF_FFF9, 4'h0, 1'b0},
    '{32'hFB42_F113, 32'h0003_0002, 32'h0005_0004, 32'hFFFF_FFFE, 4'h0, 1'b0},
    '{32'hFB42_F103, 32'h8000_8000, 32'h8000_7FFF, 32'h8000_8000, 4'h0, 1'b0},
    '{32'hFAD2_F103, 32'h0001_0005, 32'h0002_0003, 32'hFFFF_0002, 4'h3, 1'b0},
    '{32'hFAD2_F103, 32'h8000_0000, 32'h0001_0001, 32'h7FFF_FFFF, 4'h0, 1'b0},
    '{32'hFAE2_F103, 32'h0050_0000, 32'h8000_0010, 32'h0040_8000, 4'hC, 1'b0},
    '{32'hF302_111F, 32'h0000_0123, 32'h0000_0000, 32'h0000_1230, 4'hC, 1'b0},
    '{32'hF322_71DF, 32'h8000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 4'hC, 1'b0},
    '{32'hF322_0103, 32'hFFF0_0005, 32'h0000_0000, 32'hFFF8_0005, 4'hC, 1'b1},
    '{32'hF302_0107, 32'hFFFF_FF00, 32'h0000_0000, 32'hFFFF_FF80, 4'hC, 1'b1},
    '{32'hFB42_F103, 32'h0003_0002, 32'h0005_0004, 32'hFFFF_FFF9, 4'hC, 1'b1},
    '{32'hF302_0100, 32'h0000_0005, 32'h0000_0000, 32'h0000_0000, 4'hC, 1'b1}
    };

    ssdsu_unit dut (
        .clk_sys(clk_sys), .rstn(rstn), .issue(issue),
        .stores_done(stores_done), .loads_done(loads_done),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .issue_ready(issue_ready),
        .result(result), .sticky_saturation_flag(sticky_saturation_flag),
        .greater_equal_flags(greater_equal_flags), .spec_fence(spec_fence)
    );

    ssdsu_mem_model model (
        .clk_sys(clk_sys), .rstn(rstn), .spec_fence(spec_fence),
        .stores_done(stores_done), .loads_done(loads_done)
    );

    always #20 clk_sys = ~clk_sys;

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic issue_op(input logic [31:0] i, input logic [31:0] a,
                            input logic [31:0] b, input logic it);
        @(posedge clk_sys);
        issue.valid  <= 1'b1;
        issue.instr  <= i;
        issue.rn_val <= a;
        issue.rm_val <= b;
        issue.in_it  <= it;
        @(posedge clk_sys);
        issue.valid <= 1'b0;
        #1;
    endtask

    // Refused instruction: pulse only, no register write
    task automatic chk_rej(input logic u, input logic p);
        chk("valid", result.valid, 1'b0);
        chk("undef", result.undef, u);
        chk("unpred", result.unpred, p);
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_reset;
        chk("ready", issue_ready, 1'b1);
        chk("fence", spec_fence, 1'b0);
        chk("q", sticky_saturation_flag, 1'b0);
        chk("ge", greater_equal_flags, 4'h0);
        chk("valid", result.valid, 1'b0);
        reg_read(ssdsu_pkg::ADDR_CTRL, rv);
        chk("ctrl", rv, 32'h0000_0003);
        reg_read(ssdsu_pkg::ADDR_FLAGS, rv);
        chk("flags", rv, 32'h0000_0000);
    endtask

    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end

    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        issue = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_reset();
        for (int i = 0; i < 12; i++) begin
            issue_op(rows[i].ins, rows[i].a, rows[i].b, 1'b0);
            chk("valid", result.valid, 1'b1);
            chk("rd", result.rd, 4'h1);
            chk("data", result.data,
                rows[i].data);
            chk("ge", greater_equal_flags, rows[i].ge);
            chk("q", sticky_saturation_flag, rows[i].q);
        end
        // Registers 13 and 15 in each field of a three-register form
        for (int i = 0; i < 6; i++) begin
            ins = 32'hFAD2_F103;
            ins[pos_a[i/2] +: 4] = (i % 2) ? 4'hF : 4'hD;
            issue_op(ins, 32'h0001_0005, 32'h0002_0003, 1'b0);
            chk_rej(1'b0, 1'b1);
            chk("ge", greater_equal_flags, 4'hC);
        end
        issue_op(32'hF322_0F03, 32'h7FFF_7FFF, 32'h0, 1'b0);
        chk_rej(1'b0, 1'b1);
        issue_op(32'hF32D_0103, 32'h7FFF_7FFF, 32'h0, 1'b0);
        chk_rej(1'b0, 1'b1);
        reg_read(ssdsu_pkg::ADDR_FLAGS, rv);
        chk("flags", rv, 32'h0000_001C);
        reg_write(ssdsu_pkg::ADDR_FLAGS, 32'h0000_0005);
        reg_read(ssdsu_pkg::ADDR_FLAGS, rv);
        chk("flags", rv, 32'h0000_0005);
        chk("ge", greater_equal_flags, 4'h5);
        reg_write(4'h8, 32'hFFFF_FFFF);
        reg_read(4'h8, rv);
        chk("unmapped", rv, 32'h0000_0000);
        reg_write(ssdsu_pkg::ADDR_CTRL, 32'h0000_0002);
        for (int i = 0; i < 5; i++) begin
            issue_op(dsp_a[i], 32'h7FFF_0001, 32'h0001_0002, 1'b0);
            chk_rej(1'b1, 1'b0);
        end
        reg_write(ssdsu_pkg::ADDR_CTRL, 32'h0000_0001);
        issue_op(ssdsu_pkg::BARRIER_WORD, 32'h0, 32'h0, 1'b0);
        chk_rej(1'b1, 1'b0);
        chk("fence", spec_fence, 1'b0);
        reg_write(ssdsu_pkg::ADDR_CTRL, 32'h0000_0003);
        issue_op(ssdsu_pkg::BARRIER_WORD, 32'h0, 32'h0, 1'b1);
        chk_rej(1'b0, 1'b1);
        chk("fence", spec_fence, 1'b0);
        issue_op(ssdsu_pkg::BARRIER_WORD, 32'h0, 32'h0, 1'b0);
        chk("fence", spec_fence, 1'b1);
        chk("ready", issue_ready, 1'b0);
        chk("valid", result.valid, 1'b0);
        // Stores and loads drained, release not yet registered: barrier must hold
        repeat (4) @(posedge clk_sys);
        #1;
        chk("fence", spec_fence, 1'b1);
        k = 0;
        while (spec_fence === 1'b1 && k < 20) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk("fence", spec_fence, 1'b0);
        chk("ready", issue_ready, 1'b1);
        issue_op(rows[3].ins, rows[3].a, rows[3].b, 1'b0);
        chk("data", result.data, rows[3].data);
        // Clear both enables so the reset must bring them back
        reg_write(ssdsu_pkg::ADDR_CTRL, 32'h0000_0000);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_reset();
        test_done();
    end
endmodule
